// >>> eirm_pkg.sv
// Shared constants of the interrupt behaviour and quick recovery manager
package eirm_pkg;

   // ------------------------------------------------------------------
   // Serial frame layout
   // ------------------------------------------------------------------
   localparam int unsigned FRAME_BITS    = 32;
   localparam int unsigned CMD_BITS      = 8;
   localparam int unsigned ADDR_W        = 7;
   localparam int unsigned DATA_W        = 24;
   localparam logic [5:0]  CMD_LAST_EDGE = 6'h07;
   localparam logic [5:0]  LAST_EDGE     = 6'h1F;
   localparam logic [5:0]  FRAME_END     = 6'h20;

   // ------------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------------
   localparam logic [6:0] ADDR_STATUS         = 7'h01;
   localparam logic [6:0] ADDR_IRQ_MANAGER    = 7'h04;
   localparam logic [6:0] ADDR_DYNAMIC_MODE   = 7'h05;
   localparam logic [6:0] ADDR_SOFT_RESET     = 7'h08;
   localparam logic [6:0] ADDR_BEAT_INTERVAL  = 7'h25;
   localparam logic [23:0] SOFT_RESET_KEY     = 24'h000000;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int unsigned FIFO_THR_LSB   = 19;
   localparam int unsigned QCLR_POS       = 6;
   localparam int unsigned BCLR_LSB       = 4;
   localparam int unsigned TCLR_POS       = 2;
   localparam int unsigned TDIV_LSB       = 0;
   localparam int unsigned QSEL_LSB       = 22;
   localparam int unsigned QTHR_LSB       = 16;
   localparam int unsigned LIMIT_SHIFT    = 11;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [4:0] FIFO_THR_RST = 5'h0F;
   localparam logic       QCLR_RST     = 1'h0;
   localparam logic [1:0] BCLR_RST     = 2'h0;
   localparam logic       TCLR_RST     = 1'h1;
   localparam logic [1:0] TDIV_RST     = 2'h0;
   localparam logic [1:0] QSEL_RST     = 2'h0;
   localparam logic [5:0] QTHR_RST     = 6'h3F;

   // ------------------------------------------------------------------
   // Mode encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] BCLR_STATUS   = 2'h0;
   localparam logic [1:0] BCLR_INTERVAL = 2'h1;
   localparam logic [1:0] BCLR_SELF     = 2'h2;
   localparam logic [1:0] QSEL_MANUAL   = 2'h1;
   localparam logic [1:0] QSEL_AUTO     = 2'h2;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned CYCLES_PER_MS   = CLK_HZ / 1000;
   localparam int unsigned QR_SAT_TIME_MS  = 125;
   localparam int unsigned QR_HOLD_TIME_MS = 500;
   localparam int unsigned QR_SAT_CYCLES   = QR_SAT_TIME_MS * CYCLES_PER_MS;
   localparam int unsigned QR_HOLD_CYCLES  = QR_HOLD_TIME_MS * CYCLES_PER_MS;
   localparam int unsigned RATE_CNT_W      = 24;

   typedef enum logic [1:0] {
      QR_OFF   = 2'b00,
      QR_WATCH = 2'b01,
      QR_HOLD  = 2'b10
   } eirm_qr_state_type;

endpackage

// >>> eirm_link_if.sv
// Carrier between the serial link logic and the manager core
`timescale 1ns/10ps
interface eirm_link_if;
   logic        done_toggle;
   logic [6:0]  frame_addr;
   logic        frame_write;
   logic [23:0] frame_data;
   logic [23:0] irq_manager_word;
   logic [23:0] dynamic_mode_word;

   modport link (output done_toggle, frame_addr, frame_write, frame_data,
                 input irq_manager_word, dynamic_mode_word);
   modport core (input done_toggle, frame_addr, frame_write, frame_data,
                 output irq_manager_word, dynamic_mode_word);
endinterface

// >>> eirm_spi_link.sv
// Serial slave on the host's clock: frame decode, readback, frame hand-off
`timescale 1ns/10ps
module eirm_spi_link
   import eirm_pkg::*;
(
   // Link pins
   input  wire logic sclk,
   input  wire logic csb,
   input  wire logic din,
   output logic      dout,
   output logic      dout_oe,
   // Reset
   input  wire logic rst_n,
   // Core side
   eirm_link_if.link lnk
);

   logic [5:0]  bit_cnt;
   logic [22:0] shifter;
   logic        is_read;
   logic [23:0] read_word;
   logic [6:0]  cmd_addr;
   wire         at_cmd   = (bit_cnt == CMD_LAST_EDGE);
   wire         at_last  = (bit_cnt == LAST_EDGE);
   wire         data_ph  = (bit_cnt > CMD_LAST_EDGE) && (bit_cnt < FRAME_END);
   wire  [4:0]  out_idx  = 5'(6'h1F - bit_cnt);
   wire  [23:0] sel_word = (shifter[6:0] == ADDR_IRQ_MANAGER)  ? lnk.irq_manager_word :
                           (shifter[6:0] == ADDR_DYNAMIC_MODE) ? lnk.dynamic_mode_word :
                           24'h000000;

   // ------------------------------------------------------------------
   // Frame position, cleared whenever chip select is high
   // ------------------------------------------------------------------
   always_ff @(posedge sclk or negedge rst_n or posedge csb) begin
      if (!rst_n)
         bit_cnt <= 6'h00;
      else if (csb)
         bit_cnt <= 6'h00;
      else if (bit_cnt != FRAME_END)
         bit_cnt <= bit_cnt + 6'h01;
   end

   // ------------------------------------------------------------------
   // Shift in, latch command, hand the frame over at its last edge
   // ------------------------------------------------------------------
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shifter   <= 23'h000000;
         is_read   <= 1'b0;
         read_word <= 24'h000000;
         cmd_addr  <= 7'h00;
      end else begin
         shifter <= {shifter[21:0], din};
         if (at_cmd) begin
            cmd_addr  <= shifter[6:0];
            is_read   <= din;
            // Config words only move after a finished frame, so they are
            // quiet at this edge of any later frame
            read_word <= sel_word;
         end
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         lnk.done_toggle <= 1'b0;
         lnk.frame_addr  <= 7'h00;
         lnk.frame_write <= 1'b0;
         lnk.frame_data  <= 24'h000000;
      end else if (at_last && !csb) begin
         // Hand-off happens only on the 32nd rising edge
         lnk.done_toggle <= ~lnk.done_toggle;
         lnk.frame_addr  <= cmd_addr;
         lnk.frame_write <= ~is_read;
         lnk.frame_data  <= {shifter, din};
      end
   end

   // ------------------------------------------------------------------
   // Readback launched on falling edges so the host samples on rising
   // ------------------------------------------------------------------
   always_ff @(negedge sclk or negedge rst_n or posedge csb) begin
      if (!rst_n) begin
         dout    <= 1'b0;
         dout_oe <= 1'b0;
      end else if (csb) begin
         dout    <= 1'b0;
         dout_oe <= 1'b0;
      end else begin
         dout_oe <= 1'b1;
         dout    <= (is_read && data_ph) ? read_word[out_idx] : 1'b0;
      end
   end

endmodule

// >>> eirm_manager.sv
// Interrupt behaviour, sample tick and quick recovery manager (top)
//
// Behaviour
// - FIFO-level irq when unread records reach threshold plus one; threshold resets 01111.
// - Clear mode 0: quick irq held while engaged, then until status read.
// - Clear mode 1: status read clears quick irq; re-raised only on re-entry.
// - Beat irq clears on status read, interval read, or next data-rate cycle.
// - Tick clears on status read, or self-clears after a quarter data-rate cycle.
// - Tick issued every 1st, 2nd, 4th or 16th sample instant; divider resets 00.
// - Recovery select: off, manual until disabled, automatic; 11 reserved.
// - Automatic mode compares each output to plus/minus 2048 times threshold.
// - Beyond limits over 125 ms engages quick recovery for 500 ms.
// - Dynamic-mode writes apply at once without touching FIFO or resync.
// - Write to address 0x08 restores all defaults once the frame handed off at the 32nd serial edge is synchronised to clk.
// - Soft reset executes only when data word is all zero.
// - Tick divider counts ECG base-rate sample instants.
`timescale 1ns/10ps
module eirm_manager
   import eirm_pkg::*;
#(
   parameter int unsigned SAT_CYCLES  = eirm_pkg::QR_SAT_CYCLES,
   parameter int unsigned HOLD_CYCLES = eirm_pkg::QR_HOLD_CYCLES
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Serial link
   input  wire logic        sclk,
   input  wire logic        csb,
   input  wire logic        din,
   output logic             dout,
   output logic             dout_oe,
   // Channel events
   input  wire logic [5:0]  fifo_count,
   input  wire logic        sample_strobe,
   input  wire logic [17:0] ecg_sample,
   input  wire logic        beat_event,
   // Interrupt terms and controls
   output logic             fifo_level_irq,
   output logic             quick_recovery_irq,
   output logic             beat_detect_irq,
   output logic             conversion_tick_pulse,
   output logic             quick_recovery_active,
   output logic             soft_reset_pulse
);

   eirm_link_if lnk ();

   eirm_spi_link eirm_spi_link_inst (
      .sclk    (sclk),
      .csb     (csb),
      .din     (din),
      .dout    (dout),
      .dout_oe (dout_oe),
      .rst_n   (rst_n),
      .lnk     (lnk.link)
   );

   // ------------------------------------------------------------------
   // Frame hand-off from the link clock
   // ------------------------------------------------------------------
   logic tgl_s1;
   logic tgl_s2;
   logic tgl_s3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
      end else begin
         tgl_s1 <= lnk.done_toggle;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
      end
   end

   // Frame words are held in the link until the next frame ends, long after
   // this pulse, so they are stable when read here
   wire commit     = tgl_s2 ^ tgl_s3;
   wire is_wr      = commit && lnk.frame_write;
   wire is_rd      = commit && !lnk.frame_write;
   wire wr_irq_mgr = is_wr && (lnk.frame_addr == ADDR_IRQ_MANAGER);
   wire wr_dyn     = is_wr && (lnk.frame_addr == ADDR_DYNAMIC_MODE);
   wire sw_reset   = is_wr && (lnk.frame_addr == ADDR_SOFT_RESET)
                     && (lnk.frame_data == SOFT_RESET_KEY);
   wire status_rd  = is_rd && (lnk.frame_addr == ADDR_STATUS);
   wire interval_rd = is_rd && (lnk.frame_addr == ADDR_BEAT_INTERVAL);

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   logic [4:0] fifo_irq_threshold;
   logic       quick_irq_clear_mode;
   logic [1:0] beat_irq_clear_mode;
   logic       tick_pulse_clear_mode;
   logic [1:0] tick_pulse_divider;
   logic [1:0] quick_recovery_select;
   logic [5:0] quick_recovery_threshold;
   wire  [23:0] wd = lnk.frame_data;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_irq_threshold    <= FIFO_THR_RST;
         quick_irq_clear_mode  <= QCLR_RST;
         beat_irq_clear_mode   <= BCLR_RST;
         tick_pulse_clear_mode <= TCLR_RST;
         tick_pulse_divider    <= TDIV_RST;
      end else if (sw_reset) begin
         fifo_irq_threshold    <= FIFO_THR_RST;
         quick_irq_clear_mode  <= QCLR_RST;
         beat_irq_clear_mode   <= BCLR_RST;
         tick_pulse_clear_mode <= TCLR_RST;
         tick_pulse_divider    <= TDIV_RST;
      end else if (wr_irq_mgr) begin
         fifo_irq_threshold    <= wd[FIFO_THR_LSB +: 5];
         quick_irq_clear_mode  <= wd[QCLR_POS];
         beat_irq_clear_mode   <= wd[BCLR_LSB +: 2];
         tick_pulse_clear_mode <= wd[TCLR_POS];
         tick_pulse_divider    <= wd[TDIV_LSB +: 2];
      end
   end

   // Takes effect on the next clock; nothing else is restarted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quick_recovery_select    <= QSEL_RST;
         quick_recovery_threshold <= QTHR_RST;
      end else if (sw_reset) begin
         quick_recovery_select    <= QSEL_RST;
         quick_recovery_threshold <= QTHR_RST;
      end else if (wr_dyn) begin
         quick_recovery_select    <= wd[QSEL_LSB +: 2];
         quick_recovery_threshold <= wd[QTHR_LSB +: 6];
      end
   end

   assign lnk.irq_manager_word = {fifo_irq_threshold, 12'h000, quick_irq_clear_mode,
                                  beat_irq_clear_mode, 1'b0, tick_pulse_clear_mode,
                                  tick_pulse_divider};
   assign lnk.dynamic_mode_word = {quick_recovery_select, quick_recovery_threshold, 16'h0000};

   // ------------------------------------------------------------------
   // FIFO level
   // ------------------------------------------------------------------
   wire [5:0] fifo_need = {1'b0, fifo_irq_threshold} + 6'h01;
   wire       next_fifo_level_irq = (fifo_count >= fifo_need);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         fifo_level_irq <= 1'b0;
      else
         fifo_level_irq <= next_fifo_level_irq;
   end

   // ------------------------------------------------------------------
   // Automatic quick recovery
   // ------------------------------------------------------------------
   eirm_qr_state_type qr_state;
   logic [31:0]       qr_cnt;
   logic              beyond;
   wire               mode_manual = (quick_recovery_select == QSEL_MANUAL);
   wire               mode_auto   = (quick_recovery_select == QSEL_AUTO);
   wire signed [17:0] pos_limit   = 18'({quick_recovery_threshold, 11'h000});
   wire signed [17:0] neg_limit   = -pos_limit;
   wire signed [17:0] smp         = ecg_sample;
   wire               smp_beyond  = (smp > pos_limit) || (smp < neg_limit);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         beyond <= 1'b0;
      else if (sw_reset)
         beyond <= 1'b0;
      else if (sample_strobe)
         beyond <= smp_beyond;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qr_state <= QR_OFF;
         qr_cnt   <= 32'h00000000;
      end else if (sw_reset || !mode_auto) begin
         qr_state <= QR_OFF;
         qr_cnt   <= 32'h00000000;
      end else begin
         case (qr_state)
            QR_OFF: begin
               qr_cnt <= 32'h00000000;
               if (beyond)
                  qr_state <= QR_WATCH;
            end
            QR_WATCH: begin
               if (!beyond) begin
                  qr_state <= QR_OFF;
                  qr_cnt   <= 32'h00000000;
               end else if (qr_cnt >= SAT_CYCLES) begin
                  qr_state <= QR_HOLD;
                  qr_cnt   <= 32'h00000000;
               end else begin
                  qr_cnt <= qr_cnt + 32'h00000001;
               end
            end
            QR_HOLD: begin
               if (qr_cnt >= HOLD_CYCLES - 1) begin
                  qr_state <= QR_OFF;
                  qr_cnt   <= 32'h00000000;
               end else begin
                  qr_cnt <= qr_cnt + 32'h00000001;
               end
            end
            default: begin
               qr_state <= QR_OFF;
               qr_cnt   <= 32'h00000000;
            end
         endcase
      end
   end

   wire next_active = mode_manual || (mode_auto && qr_state == QR_HOLD);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         quick_recovery_active <= 1'b0;
      else if (sw_reset)
         quick_recovery_active <= 1'b0;
      else
         quick_recovery_active <= next_active;
   end

   // ------------------------------------------------------------------
   // Quick recovery interrupt
   // ------------------------------------------------------------------
   // Mode 0 keeps setting while engaged; mode 1 sets only on entry
   wire quick_entry = next_active && !quick_recovery_active;
   wire quick_set   = quick_irq_clear_mode ? quick_entry : next_active;
   wire quick_clr   = status_rd && (quick_irq_clear_mode || !next_active);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         quick_recovery_irq <= 1'b0;
      else if (sw_reset)
         quick_recovery_irq <= 1'b0;
      else if (quick_set)
         quick_recovery_irq <= 1'b1;
      else if (quick_clr)
         quick_recovery_irq <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Beat detect interrupt
   // ------------------------------------------------------------------
   wire beat_clr = (beat_irq_clear_mode == BCLR_INTERVAL) ? interval_rd :
                   (beat_irq_clear_mode == BCLR_SELF)     ? sample_strobe :
                   status_rd;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         beat_detect_irq <= 1'b0;
      else if (sw_reset)
         beat_detect_irq <= 1'b0;
      else if (beat_event)
         beat_detect_irq <= 1'b1;
      else if (beat_clr)
         beat_detect_irq <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Sample tick: divider and quarter-period self clear
   // ------------------------------------------------------------------
   logic [3:0]            tick_div_cnt;
   logic [RATE_CNT_W-1:0] period_cnt;
   logic [RATE_CNT_W-1:0] last_period;
   logic [RATE_CNT_W-1:0] tick_age;
   wire  [3:0]            div_mask = (tick_pulse_divider == 2'h0) ? 4'h0 :
                                     (tick_pulse_divider == 2'h1) ? 4'h1 :
                                     (tick_pulse_divider == 2'h2) ? 4'h3 : 4'hF;
   wire                   tick_fire = sample_strobe && ~|(tick_div_cnt & div_mask);
   wire  [RATE_CNT_W-1:0] quarter   = (last_period >> 2);
   wire                   tick_self = tick_pulse_clear_mode && (tick_age + 1'b1 >= quarter);
   wire                   tick_clr  = tick_pulse_clear_mode ? tick_self : status_rd;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_div_cnt <= 4'h0;
         period_cnt   <= '0;
         last_period  <= '0;
      end else if (sw_reset) begin
         tick_div_cnt <= 4'h0;
         period_cnt   <= '0;
         last_period  <= '0;
      end else if (sample_strobe) begin
         tick_div_cnt <= tick_div_cnt + 4'h1;
         period_cnt   <= '0;
         last_period  <= period_cnt + 1'b1;
      end else begin
         period_cnt <= period_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_tick_pulse <= 1'b0;
         tick_age              <= '0;
      end else if (sw_reset) begin
         conversion_tick_pulse <= 1'b0;
         tick_age              <= '0;
      end else if (tick_fire) begin
         conversion_tick_pulse <= 1'b1;
         tick_age              <= '0;
      end else if (conversion_tick_pulse && tick_clr) begin
         conversion_tick_pulse <= 1'b0;
      end else if (conversion_tick_pulse) begin
         tick_age <= tick_age + 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Soft reset indication to the rest of the device
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         soft_reset_pulse <= 1'b0;
      else
         soft_reset_pulse <= sw_reset;
   end

endmodule

// >>> eirm_sva.sv
// Checker on the manager's top-level ports
`timescale 1ns/10ps
module eirm_manager_sva #(
   parameter int unsigned SAT_CYCLES  = 20,
   parameter int unsigned HOLD_CYCLES = 40
)(
   // Clock, reset and link
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       csb,
   input wire logic       dout_oe,
   // Channel events
   input wire logic [5:0] fifo_count,
   input wire logic       sample_strobe,
   input wire logic       beat_event,
   // Interrupt terms
   input wire logic       fifo_level_irq,
   input wire logic       quick_recovery_irq,
   input wire logic       beat_detect_irq,
   input wire logic       conversion_tick_pulse,
   input wire logic       quick_recovery_active,
   input wire logic       soft_reset_pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Threshold plus one spans 1..32, so both ends hold for any setting
   a_fifo_empty: assert property (fifo_count == 6'h00 |=> !fifo_level_irq)
      else $error("fifo irq with no records");
   a_fifo_full: assert property (fifo_count == 6'h20 |=> fifo_level_irq)
      else $error("fifo irq missing at 32 records");
   a_beat_sets: assert property (beat_event |=> beat_detect_irq)
      else $error("beat irq not raised");
   a_beat_cause: assert property ($rose(beat_detect_irq) |-> $past(beat_event))
      else $error("beat irq without beat");
   a_tick_cause: assert property ($rose(conversion_tick_pulse) |-> $past(sample_strobe))
      else $error("tick off the sample instant");
   a_quick_cause: assert property ($rose(quick_recovery_irq) |->
      quick_recovery_active || $past(quick_recovery_active))
      else $error("quick irq without recovery");
   a_soft_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse too long");
   a_link_idle: assert property (csb |-> !dout_oe)
      else $error("dout driven while deselected");
endmodule

// >>> eirm_host.sv
// Serial host model: 32-bit frames on a 160 ns link clock
`timescale 1ns/10ps
module eirm_host (
   // Link pins
   output logic      sclk,
   output logic      csb,
   output logic      din,
   input  wire logic dout
);
   initial begin
      sclk = 1'b0;
      csb  = 1'b1;
      din  = 1'b0;
   end
   // Clock stands low between frames; read bits taken at rising edges
   task automatic xfer(input logic [6:0] a, input logic r, input logic [23:0] d,
                       output logic [23:0] q);
      logic [31:0] f;
      f = {a, r, d};
      q = 24'h000000;
      csb = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         din = f[i];
         #80 sclk = 1'b1;
         if (i < 24) q[i] = dout;
         #80 sclk = 1'b0;
      end
      #80 csb = 1'b1;
      // Released line flips so a stale bit is never mistaken for data
      din = ~din;
      #120;
   endtask
endmodule

// >>> eirm_manager_tb.sv
// Self-checking bench of the manager
`timescale 1ns/10ps
module eirm_manager_tb;
   import eirm_pkg::*;
   logic               clk, rst_n, sclk, csb, din, dout, dout_oe;
   logic               sample_strobe, beat_event, sen;
   logic [5:0]         fifo_count;
   logic signed [17:0] ecg_sample;
   logic               fifo_level_irq, quick_recovery_irq, beat_detect_irq;
   logic               conversion_tick_pulse, quick_recovery_active, soft_reset_pulse;
   logic [23:0]        rd;
   logic signed [17:0] lv [4] = '{18'sh00800, -18'sh00800, 18'sh00801, -18'sh00801};
   int                 num_errors, n_tests, ticks, srs, cyc, sph;
   eirm_manager #(.SAT_CYCLES(20), .HOLD_CYCLES(40)) eirm_manager_inst (.clk, .rst_n, .sclk,
      .csb, .din, .dout, .dout_oe, .fifo_count, .sample_strobe, .ecg_sample, .beat_event,
      .fifo_level_irq, .quick_recovery_irq, .beat_detect_irq, .conversion_tick_pulse,
      .quick_recovery_active, .soft_reset_pulse);
   eirm_host eirm_host_inst (.sclk, .csb, .din, .dout);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Sample instants every 40 cycles while enabled
   always @(negedge clk) begin
      sph <= (sph == 39) ? 0 : sph + 1;
      sample_strobe <= sen && (sph == 0);
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (soft_reset_pulse === 1'b1) srs <= srs + 1;
      if ($rose(conversion_tick_pulse)) ticks <= ticks + 1;
      if (cyc == 70000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic check(input string w, input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s: expected %h, seen %h", w, exp, got);
      end
   endtask
   task automatic xf(input logic [6:0] a, input logic r, input logic [23:0] d);
      @(negedge clk);
      #1.3 eirm_host_inst.xfer(a, r, d, rd);
      repeat (6) @(negedge clk);
   endtask
   function automatic logic [23:0] mi(input logic [4:0] t, input logic q,
                                      input logic [1:0] b, input logic c, input logic [1:0] d);
      return {t, 12'h000, q, b, 1'b0, c, d};
   endfunction
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      {rst_n, beat_event, sen, sample_strobe, sph, cyc, srs, ticks} = '0;
      fifo_count = 6'h00;
      ecg_sample = 18'sd0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      xf(ADDR_IRQ_MANAGER, 1'b1, 24'h000000);
      check("irq cfg", rd, 24'h780004);
      xf(ADDR_DYNAMIC_MODE, 1'b1, 24'h000000);
      check("dyn cfg", rd, 24'h3F0000);
      for (int t = 0; t < 32; t += 31) begin
         xf(ADDR_IRQ_MANAGER, 1'b0, mi(t[4:0], 1'b0, 2'h0, 1'b1, 2'h0));
         fifo_count = t[5:0];
         repeat (3) @(negedge clk);
         check("fifo below", fifo_level_irq, 1'b0);
         fifo_count = t[5:0] + 6'h01;
         repeat (3) @(negedge clk);
         check("fifo at", fifo_level_irq, 1'b1);
      end
      $display("Test fifo level done");
      sen = 1'b1;
      for (int d = 0; d < 4; d++) begin
         xf(ADDR_IRQ_MANAGER, 1'b0, mi(5'h0F, 1'b0, 2'h0, 1'b1, d[1:0]));
         @(posedge clk iff sample_strobe);
         @(negedge clk);
         ticks = 0;
         repeat (640) @(negedge clk);
         check("ticks", ticks, (d == 3) ? 1 : 16 >> d);
      end
      xf(ADDR_IRQ_MANAGER, 1'b0, mi(5'h0F, 1'b0, 2'h0, 1'b0, 2'h0));
      sen = 1'b0;
      repeat (50) @(negedge clk);
      check("tick held", conversion_tick_pulse, 1'b1);
      xf(ADDR_STATUS, 1'b1, 24'h000000);
      check("tick cleared", conversion_tick_pulse, 1'b0);
      $display("Test tick done");
      for (int m = 0; m < 4; m++) begin
         xf(ADDR_IRQ_MANAGER, 1'b0, mi(5'h0F, 1'b0, m[1:0], 1'b1, 2'h0));
         beat_event = 1'b1;
         @(negedge clk);
         beat_event = 1'b0;
         xf((m == 1) ? ADDR_STATUS : ADDR_BEAT_INTERVAL, 1'b1, 24'h000000);
         check("beat kept", beat_detect_irq, 1'b1);
         sen = (m == 2);
         repeat (45) @(negedge clk);
         sen = 1'b0;
         if (m != 2) xf((m == 1) ? ADDR_BEAT_INTERVAL : ADDR_STATUS, 1'b1, 24'h000000);
         check("beat cleared", beat_detect_irq, 1'b0);
      end
      $display("Test beat done");
      for (int q = 0; q < 2; q++) begin
         xf(ADDR_IRQ_MANAGER, 1'b0, mi(5'h0F, q[0], 2'h0, 1'b1, 2'h0));
         xf(ADDR_DYNAMIC_MODE, 1'b0, 24'h7F0000);
         xf(ADDR_STATUS, 1'b1, 24'h000000);
         check("manual on", quick_recovery_active, 1'b1);
         check("quick irq", quick_recovery_irq, !q);
         xf(ADDR_DYNAMIC_MODE, 1'b0, 24'h3F0000);
         check("quick after", quick_recovery_irq, !q);
         xf(ADDR_STATUS, 1'b1, 24'h000000);
         check("quick cleared", quick_recovery_irq, 1'b0);
      end
      xf(ADDR_DYNAMIC_MODE, 1'b0, 24'h810000);
      sen = 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk iff sample_strobe);
         @(negedge clk);
         ecg_sample = lv[k];
         repeat (75) @(negedge clk);
         check("auto engage", quick_recovery_active, k[1]);
         ecg_sample = 18'sd0;
         repeat (200) @(negedge clk);
         check("auto release", quick_recovery_active, 1'b0);
      end
      check("fifo undisturbed", fifo_level_irq, 1'b1);
      $display("Test recovery done");
      {sen, fifo_count} = '0;
      xf(ADDR_DYNAMIC_MODE, 1'b0, 24'hC00000);
      check("reserved select", quick_recovery_active, 1'b0);
      xf(ADDR_SOFT_RESET, 1'b0, 24'h000001);
      xf(ADDR_DYNAMIC_MODE, 1'b1, 24'h000000);
      check("bad key", rd, 24'hC00000);
      xf(ADDR_SOFT_RESET, 1'b0, SOFT_RESET_KEY);
      check("reset pulse", srs, 1);
      xf(ADDR_IRQ_MANAGER, 1'b1, 24'h000000);
      check("irq cfg reset", rd, 24'h780004);
      $display("Test soft reset done");
      wrap_up();
   end
endmodule
bind eirm_manager eirm_manager_sva #(.SAT_CYCLES(SAT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES))
   eirm_manager_sva_inst (.clk, .rst_n, .csb, .dout_oe, .fifo_count, .sample_strobe,
   .beat_event, .fifo_level_irq, .quick_recovery_irq, .beat_detect_irq,
   .conversion_tick_pulse, .quick_recovery_active, .soft_reset_pulse);
